// File: rtl/mxs_regs.vh
// register map, field positions and timing constants of the path controller
// assumes core_clk at 200 MHz; included by the controller files
//
// Contract
// - join two ports by asserting their select lines, pins 3 to 13
// - assert is ground on ground variants, logic high on logic-level
// - open a path by releasing ground or driving logic low
// - keep every select line but the chosen two deasserted; make-before-break keeps the old ports asserted beside them during the wait
// - hold selects asserted while the path must stay closed; no pulses
// - all selects off with open-all asserted opens every port
// - open-all may be tied asserted to open all ports at power-up
// - break-before-make drops the old port before asserting the new
// - make-before-break holds old port, waits 15 ms, then drops it
`ifndef MXS_REGS_VH
`define MXS_REGS_VH

`define MXS_ADDR_CTRL 4'h0
`define MXS_ADDR_PATH 4'h1
`define MXS_ADDR_STAT 4'h2
`define MXS_ADDR_IND 4'h3

`define MXS_CTRL_LOGIC 0
`define MXS_CTRL_MBB 1
`define MXS_CTRL_OPENALL 2
`define MXS_CTRL_NOOPENALL 3

`define MXS_STAT_BUSY 0
`define MXS_STAT_DONE 1
`define MXS_STAT_FAIL 2

`define MXS_SETTLE_MS 15
`define MXS_CLK_KHZ 200000
`define MXS_SETTLE_CYC (`MXS_SETTLE_MS * `MXS_CLK_KHZ)

`endif

// File: rtl/mxs_timer.v
// settle timer: counts a load value down and pulses when it expires
// assumes one clock, synchronous active-high reset
module mxs_timer #(
   parameter CNT_W = 22
) (
   input wire core_clk,
   input wire sys_rst,
   input wire startPulse,
   input wire [CNT_W-1:0] loadValue,
   output wire expirePulse,
   output wire running
);
   reg [CNT_W-1:0] cnt_q;
   reg run_q;
   always @(posedge core_clk) begin
      if (sys_rst) begin
         cnt_q <= {CNT_W{1'b0}};
         run_q <= 1'b0;
      end else if (startPulse) begin
         cnt_q <= loadValue;
         run_q <= 1'b1;
      end else if (run_q) begin
         if (cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1})
            run_q <= 1'b0;
         else
            cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end
   assign expirePulse = run_q && (cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1});
   assign running = run_q;
endmodule // mxs_timer

// File: rtl/mxs_path_ctrl.v
// host-side path controller for a six-port latching matrix switch
// assumes an Avalon-MM master, switch pins driven through level shifters
`include "mxs_regs.vh"
module mxs_path_ctrl #(
   parameter SETTLE_CYC = `MXS_SETTLE_CYC,
   parameter CNT_W = 22
) (
   input wire core_clk,
   input wire sys_rst,
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   output wire [5:0] selDrive,
   output wire openAllDrive,
   input wire [5:0] indClosed
);
   localparam S_IDLE = 4'b0001;
   localparam S_MAKE = 4'b0010;
   localparam S_WAIT = 4'b0100;
   localparam S_FIN = 4'b1000;

   reg [3:0] ctrl_q;
   reg [5:0] pathReq_q;
   reg [5:0] selAct_q;
   reg [5:0] target_q;
   reg [3:0] state_q;
   reg [3:0] state_d;
   reg done_q;
   reg fail_q;
   reg ack_q;
   reg [CNT_W-1:0] stableLen;
   wire timerStart;
   wire timerExpire;
   wire timerRun;
   wire logicLevel;
   wire [5:0] selActive;
   wire openAllAct;
   wire busy;
   wire pathWrite;

   // count of set bits; a path needs exactly two
   function [2:0] popCount;
      input [5:0] v;
      integer i;
      begin
         popCount = 3'h0;
         for (i = 0; i < 6; i = i + 1)
            popCount = popCount + {2'h0, v[i]};
      end
   endfunction

   assign logicLevel = ctrl_q[`MXS_CTRL_LOGIC];
   assign busy = (state_q != S_IDLE);
   // one-cycle wait state keeps read data registered
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   assign pathWrite = avs_write && ack_q
      && (avs_address == `MXS_ADDR_PATH);

   always @(posedge core_clk) begin
      if (sys_rst)
         ack_q <= 1'b0;
      else
         ack_q <= (avs_read || avs_write) && !ack_q;
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         ctrl_q <= 4'h0;
         pathReq_q <= 6'h00;
         avs_readdata <= 32'h0000_0000;
      end else begin
         if (avs_write && ack_q && avs_address == `MXS_ADDR_CTRL)
            ctrl_q <= avs_writedata[3:0];
         // a request with other than zero or two ports is dropped
         if (pathWrite && !busy && popCount(avs_writedata[5:0]) == 3'h2)
            pathReq_q <= avs_writedata[5:0];
         if (pathWrite && !busy && avs_writedata[5:0] == 6'h00)
            pathReq_q <= 6'h00;
         if (avs_read && !ack_q) begin
            case (avs_address)
               `MXS_ADDR_CTRL: avs_readdata <= {28'h0, ctrl_q};
               `MXS_ADDR_PATH: avs_readdata <= {26'h0, selAct_q};
               `MXS_ADDR_STAT:
                  avs_readdata <= {29'h0, fail_q, done_q, busy};
               `MXS_ADDR_IND: avs_readdata <= {26'h0, indClosed};
               default: avs_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   always @* begin
      state_d = state_q;
      case (state_q)
         S_IDLE: if (pathReq_q != selAct_q) state_d = S_MAKE;
         S_MAKE: state_d = S_WAIT;
         S_WAIT: if (timerExpire) state_d = S_FIN;
         S_FIN: state_d = S_IDLE;
         default: state_d = S_IDLE;
      endcase
   end

   assign timerStart = (state_q == S_MAKE);

   always @* begin
      stableLen = SETTLE_CYC[CNT_W-1:0];
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         state_q <= S_IDLE;
         selAct_q <= 6'h00;
         target_q <= 6'h00;
         done_q <= 1'b0;
         fail_q <= 1'b0;
      end else begin
         state_q <= state_d;
         case (state_q)
            S_IDLE: if (pathReq_q != selAct_q) begin
               target_q <= pathReq_q;
               done_q <= 1'b0;
               fail_q <= 1'b0;
               if (ctrl_q[`MXS_CTRL_MBB])
                  selAct_q <= selAct_q | pathReq_q; // keep old
               else
                  selAct_q <= selAct_q & pathReq_q; // drop old
            end
            S_MAKE: if (!ctrl_q[`MXS_CTRL_MBB])
               selAct_q <= target_q; // new after old released
            S_WAIT: if (timerExpire)
               selAct_q <= target_q; // old dropped after wait
            S_FIN: begin
               done_q <= 1'b1;
               // indicators confirm closure
               // only the wanted ports: a port just dropped may still show
               fail_q <= ((indClosed & target_q) != target_q);
            end
            default: selAct_q <= selAct_q;
         endcase
      end
   end

   // 15 ms settle counted from the core clock
   mxs_timer #(.CNT_W(CNT_W)) uTimer (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .startPulse(timerStart),
      .loadValue(stableLen),
      .expirePulse(timerExpire),
      .running(timerRun)
   );

   // levels held, never pulsed
   assign selActive = selAct_q;
   // active-low for ground-driven, active-high for logic-level
   // release is the inverse level
   assign selDrive = logicLevel ? selActive : ~selActive;
   // open-all only when no port selected and variant has it
   assign openAllAct = ctrl_q[`MXS_CTRL_OPENALL]
      && !ctrl_q[`MXS_CTRL_NOOPENALL] && (selActive == 6'h00);
   assign openAllDrive = logicLevel ? openAllAct : ~openAllAct;
endmodule // mxs_path_ctrl

// File: testbench/mxs_path_ctrl_props.sv
// port checker for the path controller
// assumes one clock, sync active-high reset
module mxs_path_ctrl_props #(
   parameter SETTLE_CYC = 20
) (
   input logic core_clk,
   input logic sys_rst,
   input logic [3:0] avs_address,
   input logic avs_read,
   input logic avs_write,
   input logic [31:0] avs_readdata,
   input logic avs_waitrequest,
   input logic [5:0] selDrive,
   input logic openAllDrive
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   wire req = avs_read | avs_write;
   int quiet = 0;
   sequence sWait; req && avs_waitrequest; endsequence
   sequence sIdle; !avs_read ##1 !avs_read; endsequence
   // cycles since a write; selects must settle after the longest sequence
   always @(posedge core_clk)
      quiet <= (sys_rst || (avs_write && !avs_waitrequest)) ? 0 : quiet + 1;
   chk_wait_first: assert property ($rose(req) |-> avs_waitrequest)
      else $error("no wait state");
   chk_wait_end: assert property (sWait |=> !avs_waitrequest)
      else $error("wait too long");
   chk_wait_idle: assert property (!req |-> !avs_waitrequest)
      else $error("idle wait");
   chk_rd_stands: assert property (sIdle |-> $stable(avs_readdata))
      else $error("read data moved");
   chk_rd_unmapped: assert property (avs_read && !avs_waitrequest &&
      avs_address > 4'h3 |-> avs_readdata == 32'h0) else $error("bad read");
   chk_reset_idle: assert property ($fell(sys_rst) |->
      selDrive == 6'h3F && openAllDrive) else $error("bad reset");
   chk_no_swap: assert property (
      !(|($past(selDrive) & ~selDrive) && |(~$past(selDrive) & selDrive)))
      else $error("swap in one cycle");
   chk_sel_hold: assert property (quiet > SETTLE_CYC + 8 |->
      $stable(selDrive)) else $error("select moved");
endmodule // mxs_path_ctrl_props
bind mxs_path_ctrl mxs_path_ctrl_props #(.SETTLE_CYC(SETTLE_CYC)) chk (
   .core_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_readdata,
   .avs_waitrequest, .selDrive, .openAllDrive);

// File: testbench/mxs_switch_model.sv
// six-port latching switch seen from its pins
// assumes variant level from the bench; jam is a bench-made fault
module mxs_switch_model (
   input logic core_clk,
   input logic [5:0] selDrive,
   input logic openAllDrive,
   input logic logicLvl,
   input logic [5:0] jam,
   output logic [5:0] indClosed
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [5:0] want, pend = 6'h00, held = 6'h00;
   // selected close, rest open
   // open-all adds nothing then
   assign want = logicLvl ? selDrive : ~selDrive;
   // two cycles of travel, then latched and current cut
   always @(posedge core_clk) begin
      pend <= want;
      held <= pend;
   end
   assign indClosed = held ^ jam;
endmodule // mxs_switch_model

// File: testbench/tb_mxs_path_ctrl.sv
// bench for the path controller beside a switch model
// assumes the settle count cut to 20 cycles
module tb_mxs_path_ctrl;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, logicLvl = 0;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, got;
   logic avs_waitrequest, openAllDrive;
   logic [5:0] selDrive, indClosed, e, jam = 6'h00;
   int err_count = 0, samples_checked = 0;
   // ctrl over path; variant changes only after an empty path
   logic [11:0] rows [9] = '{12'h012, 12'h221, 12'h000, 12'h400, 12'hC00,
      12'h10C, 12'h330, 12'h100, 12'h500};
   always #2.5 core_clk = ~core_clk;
   mxs_path_ctrl #(.SETTLE_CYC(20)) dut (.core_clk, .sys_rst, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
      .selDrive, .openAllDrive, .indClosed);
   mxs_switch_model sw (.core_clk, .selDrive, .openAllDrive, .logicLvl,
      .jam, .indClosed);
   task automatic results;
      $display("errors %0d checks %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] x, input logic [31:0] a);
      samples_checked++;
      if (a !== x) begin
         err_count++;
         $display("wrong value %0t exp %h got %h", $time, x, a);
      end
   endtask
   task automatic acc(input logic [3:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
         if (n > 40) begin
            err_count++;
            results();
         end
      end while (avs_waitrequest !== 1'b0);
      // taken at the edge that sees waitrequest low
      got = avs_readdata;
      avs_write <= 0;
      avs_read <= 0;
   endtask
   task automatic settle;
      for (int n = 0; n < 60; n++) begin
         acc(4'h2, 0, 0);
         if (got[1:0] === 2'b10)
            return;
      end
      err_count++;
      results();
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      sys_rst <= 0;
      foreach (rows[i]) begin
         acc(4'h0, 1, rows[i][11:8]);
         logicLvl <= rows[i][8];
         acc(4'h1, 1, rows[i][5:0]);
         settle;
         chk(32'h2, got);
         e = rows[i][8] ? rows[i][5:0] : ~rows[i][5:0];
         chk(e, selDrive);
         if (rows[i][5:0] == 6'h00)
            chk({31'h0, rows[i][8] ~^ (rows[i][10] & !rows[i][11])},
               openAllDrive);
         acc(4'h1, 0, 0);
         chk(rows[i][5:0], got);
         acc(4'h3, 0, 0);
         chk(rows[i][5:0], got);
      end
      acc(4'h0, 1, 0);
      logicLvl <= 0;
      acc(4'h1, 1, 6'h12);
      settle;
      acc(4'h1, 1, 6'h07);
      acc(4'h1, 1, 6'h21);
      repeat (8) @(negedge core_clk);
      chk(6'h1E, selDrive);
      acc(4'h1, 1, 6'h0C);
      settle;
      acc(4'h1, 0, 0);
      chk(6'h21, got);
      acc(4'h0, 1, 2);
      acc(4'h1, 1, 6'h0C);
      repeat (8) @(negedge core_clk);
      chk(6'h12, selDrive);
      settle;
      chk(6'h33, selDrive);
      jam <= 6'h01;
      acc(4'h1, 1, 6'h21);
      settle;
      chk(32'h6, got);
      jam <= 6'h00;
      acc(4'h9, 0, 0);
      chk(32'h0, got);
      sys_rst <= 1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 0;
      @(negedge core_clk);
      chk(6'h3F, selDrive);
      results();
   end
endmodule // tb_mxs_path_ctrl
